/* simc_consts.vh */
`ifndef SIMC_CONSTS_VH
`define SIMC_CONSTS_VH
// rate codes
`define SIMC_RATE_HD 1'b0
`define SIMC_RATE_SD 1'b1
// operating mode codes
`define SIMC_MODE_THRU 2'h0
`define SIMC_MODE_VIDEO 2'h1
`define SIMC_MODE_TS 2'h2
// upper lane usage codes
`define SIMC_UPPER_UNUSED 2'h0
`define SIMC_UPPER_CHROMA 2'h1
`define SIMC_UPPER_RAW 2'h2
// timing source codes
`define SIMC_TSRC_HVF 2'h0
`define SIMC_TSRC_SYNC 2'h1
`define SIMC_TSRC_EMBED 2'h2
// data path
`define SIMC_LANE_W 10
`define SIMC_WORD_W 20
`define SIMC_FIFO_DEPTH 4
`define SIMC_FIFO_AW 2
`endif

/* simc_fifo.v */
`timescale 1ns/10ps
`default_nettype none
module simc_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk, // clock
  input wire rst, // sync reset
  input wire in_valid, // write request
  output wire in_ready, // space free
  input wire [WIDTH-1:0] in_data, // write data
  output wire out_valid, // data held
  input wire out_ready, // consumer takes
  output wire [WIDTH-1:0] out_data // head word
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem_reg[rptr_reg];
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // simc_fifo
`default_nettype wire

/* simc_top.v */
// Functional notes
// - rate select 0 is HD, 1 is SD
// - 20-bit video mode, upper lanes carry chroma
// - 20-bit data-through, upper lanes pass raw
// - transport-stream mode ignores upper lanes
// - timing select low uses external strobes
// - timing select high uses embedded references
// - sync style low uses blanking/field flags
// - sync style high uses hsync/vsync/de
// - decode video, transport-stream, data-through modes
// - ignore vertical inputs when embedded timing
`timescale 1ns/10ps
`default_nettype none
`include "simc_consts.vh"
module simc_top (
  input wire clk, // parallel clock
  input wire rst, // sync reset, active high
  input wire rate_select, // 0 hd, 1 sd
  input wire bus_width_select, // 1 twenty-bit bus
  input wire processing_enable, // 1 video processing
  input wire transport_stream_mode_select, // 1 transport stream
  input wire timing_source_select, // 1 embedded timing
  input wire sync_style_select, // 1 sync/de strobes
  input wire [`SIMC_LANE_W-1:0] din_lower, // lower lanes, luma or words
  input wire [`SIMC_LANE_W-1:0] din_upper, // upper lanes
  input wire din_valid, // source word valid
  output wire din_ready, // fifo can take word
  input wire h_blank, // horizontal blanking flag
  input wire v_blank, // vertical blanking flag
  input wire f_field, // field flag
  input wire h_sync, // horizontal sync
  input wire v_sync, // vertical sync
  input wire data_en, // data enable
  output wire rate_sd, // 1 sd rate selected
  output wire [1:0] op_mode, // operating mode code
  output wire [1:0] upper_use, // upper lane usage code
  output wire [1:0] timing_src, // timing source code
  output wire tim_h, // selected horizontal timing
  output wire tim_v, // selected vertical timing
  output wire tim_f, // selected field/enable timing
  output wire word_valid, // word available
  input wire word_ready, // downstream takes word
  output wire [`SIMC_LANE_W-1:0] word_lower, // lower lanes out
  output wire [`SIMC_LANE_W-1:0] word_upper, // upper lanes out
  output wire word_upper_used // upper lanes meaningful
);
  //////////////////////////////////////////////////////////////////////////
  // decoded control pins
  wire mode_is_video;
  wire mode_is_ts;
  wire mode_is_thru;
  wire wide_bus;
  wire timing_embedded;
  wire timing_sync_style;
  reg rate_next;
  reg [1:0] mode_next;
  reg [1:0] upper_next;
  reg [1:0] tsrc_next;
  reg h_next;
  reg v_next;
  reg f_next;
  reg upper_keep;
  wire [`SIMC_LANE_W-1:0] upper_data_next;
  wire [`SIMC_WORD_W-1:0] fifo_in;
  wire [`SIMC_WORD_W-1:0] fifo_out;
  wire fifo_valid;
  wire fifo_ready;
  wire word_take;
  reg rate_sd_reg;
  reg [1:0] op_mode_reg;
  reg [1:0] upper_use_reg;
  reg [1:0] timing_src_reg;
  reg tim_h_reg;
  reg tim_v_reg;
  reg tim_f_reg;
  reg out_full_reg;
  reg [`SIMC_LANE_W-1:0] word_lower_reg;
  reg [`SIMC_LANE_W-1:0] word_upper_reg;
  reg word_upper_used_reg;
  assign mode_is_video = processing_enable;
  assign mode_is_ts = ~processing_enable & transport_stream_mode_select;
  assign mode_is_thru = ~processing_enable & ~transport_stream_mode_select;
  assign wide_bus = bus_width_select;
  assign timing_embedded = timing_source_select;
  assign timing_sync_style = sync_style_select;
  //////////////////////////////////////////////////////////////////////////
  // serial rate
  always @* begin
    if (rate_select) begin
      rate_next = `SIMC_RATE_SD;
    end else begin
      rate_next = `SIMC_RATE_HD;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // operating mode
  always @* begin
    mode_next = `SIMC_MODE_THRU;
    case ({mode_is_video, mode_is_ts, mode_is_thru})
      3'h4: begin
        mode_next = `SIMC_MODE_VIDEO;
      end
      3'h2: begin
        mode_next = `SIMC_MODE_TS;
      end
      3'h1: begin
        mode_next = `SIMC_MODE_THRU;
      end
      default: begin
        mode_next = `SIMC_MODE_THRU;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////
  // upper lane usage
  always @* begin
    upper_next = `SIMC_UPPER_UNUSED;
    if (wide_bus) begin
      case (mode_next)
        `SIMC_MODE_VIDEO: begin
          upper_next = `SIMC_UPPER_CHROMA;
        end
        `SIMC_MODE_THRU: begin
          upper_next = `SIMC_UPPER_RAW;
        end
        `SIMC_MODE_TS: begin
          upper_next = `SIMC_UPPER_UNUSED;
        end
        default: begin
          upper_next = `SIMC_UPPER_UNUSED;
        end
      endcase
    end
  end
  always @* begin
    upper_keep = 1'b0;
    if (upper_next != `SIMC_UPPER_UNUSED) begin
      upper_keep = 1'b1;
    end
  end
  // unused upper lanes enter the buffer as zero
  genvar lane;
  generate
    for (lane = 0; lane < `SIMC_LANE_W; lane = lane + 1) begin : g_upper_lane
      assign upper_data_next[lane] = din_upper[lane] & upper_keep;
    end
  endgenerate
  assign fifo_in = {upper_data_next, din_lower};
  //////////////////////////////////////////////////////////////////////////
  // timing source steering
  always @* begin
    if (timing_embedded) begin
      tsrc_next = `SIMC_TSRC_EMBED;
    end else if (timing_sync_style) begin
      tsrc_next = `SIMC_TSRC_SYNC;
    end else begin
      tsrc_next = `SIMC_TSRC_HVF;
    end
  end
  always @* begin
    case (tsrc_next)
      `SIMC_TSRC_HVF: begin
        h_next = h_blank;
      end
      `SIMC_TSRC_SYNC: begin
        h_next = h_sync;
      end
      default: begin
        h_next = 1'b0;
      end
    endcase
  end
  always @* begin
    case (tsrc_next)
      `SIMC_TSRC_HVF: begin
        v_next = v_blank;
      end
      `SIMC_TSRC_SYNC: begin
        v_next = v_sync;
      end
      default: begin
        v_next = 1'b0;
      end
    endcase
  end
  always @* begin
    case (tsrc_next)
      `SIMC_TSRC_HVF: begin
        f_next = f_field;
      end
      `SIMC_TSRC_SYNC: begin
        f_next = data_en;
      end
      default: begin
        f_next = 1'b0;
      end
    endcase
  end
  //////////////////////////////////////////////////////////////////////////
  // registered settings
  always @(posedge clk) begin
    if (rst) begin
      rate_sd_reg <= `SIMC_RATE_HD;
    end else begin
      rate_sd_reg <= rate_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      op_mode_reg <= `SIMC_MODE_THRU;
    end else begin
      op_mode_reg <= mode_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      upper_use_reg <= `SIMC_UPPER_UNUSED;
    end else begin
      upper_use_reg <= upper_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      timing_src_reg <= `SIMC_TSRC_HVF;
    end else begin
      timing_src_reg <= tsrc_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      tim_h_reg <= 1'b0;
    end else begin
      tim_h_reg <= h_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      tim_v_reg <= 1'b0;
    end else begin
      tim_v_reg <= v_next;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      tim_f_reg <= 1'b0;
    end else begin
      tim_f_reg <= f_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // word buffer with output register stage
  simc_fifo #(
    .WIDTH(`SIMC_WORD_W),
    .DEPTH(`SIMC_FIFO_DEPTH),
    .AW(`SIMC_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(din_valid),
    .in_ready(din_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out)
  );
  assign fifo_ready = ~out_full_reg | word_ready;
  assign word_take = fifo_ready & fifo_valid;
  always @(posedge clk) begin
    if (rst) begin
      out_full_reg <= 1'b0;
    end else if (fifo_ready) begin
      out_full_reg <= fifo_valid;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      word_lower_reg <= {`SIMC_LANE_W{1'b0}};
    end else if (word_take) begin
      word_lower_reg <= fifo_out[`SIMC_LANE_W-1:0];
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      word_upper_reg <= {`SIMC_LANE_W{1'b0}};
    end else if (word_take) begin
      word_upper_reg <= fifo_out[`SIMC_WORD_W-1:`SIMC_LANE_W];
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      word_upper_used_reg <= 1'b0;
    end else if (word_take) begin
      word_upper_used_reg <= (upper_use_reg != `SIMC_UPPER_UNUSED);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // outputs straight from the registers
  assign rate_sd = rate_sd_reg;
  assign op_mode = op_mode_reg;
  assign upper_use = upper_use_reg;
  assign timing_src = timing_src_reg;
  assign tim_h = tim_h_reg;
  assign tim_v = tim_v_reg;
  assign tim_f = tim_f_reg;
  assign word_valid = out_full_reg;
  assign word_lower = word_lower_reg;
  assign word_upper = word_upper_reg;
  assign word_upper_used = word_upper_used_reg;
endmodule // simc_top
`default_nettype wire

/* simc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "simc_consts.vh"
module simc_monitor (
  input wire logic clk, rst, rate_select, bus_width_select, processing_enable,
  input wire logic transport_stream_mode_select, timing_source_select, sync_style_select,
  input wire logic h_blank, v_blank, f_field, h_sync, v_sync, data_en, rate_sd,
  input wire logic [1:0] op_mode, upper_use, timing_src,
  input wire logic tim_h, tim_v, tim_f, word_valid, word_ready
);
  wire pe = processing_enable;
  wire ts = transport_stream_mode_select;
  wire bw = bus_width_select;
  wire tr = timing_source_select;
  wire [2:0] flg = {h_blank, v_blank, f_field};
  wire [2:0] syn = {h_sync, v_sync, data_en};
  wire [2:0] tim = {tim_h, tim_v, tim_f};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rate_sel: assert property (1 |=> rate_sd == $past(rate_select)) else $error("rate");
  a_mode_video: assert property (pe |=> op_mode == `SIMC_MODE_VIDEO) else $error("mode");
  a_mode_ts: assert property (!pe && ts |=> op_mode == `SIMC_MODE_TS) else $error("mode");
  a_mode_thru: assert property (!pe && !ts |=> op_mode == `SIMC_MODE_THRU) else $error("mode");
  a_upper_chroma: assert property (bw && pe |=> upper_use == `SIMC_UPPER_CHROMA)
    else $error("upper");
  a_upper_raw: assert property (bw && !pe && !ts |=> upper_use == `SIMC_UPPER_RAW)
    else $error("upper");
  a_upper_off: assert property (!bw || (!pe && ts) |=> upper_use == 2'h0)
    else $error("upper");
  a_tim_embed: assert property (tr |=> timing_src == `SIMC_TSRC_EMBED && tim == 3'h0)
    else $error("timing");
  a_tim_flags: assert property (!tr && !sync_style_select |=> tim == $past(flg))
    else $error("timing");
  a_tim_sync: assert property (!tr && sync_style_select |=> tim == $past(syn))
    else $error("timing");
  c_word: cover property (word_valid && word_ready);
  c_ts: cover property (op_mode == `SIMC_MODE_TS);
  c_sync: cover property (timing_src == `SIMC_TSRC_SYNC);
endmodule // simc_monitor
bind simc_top simc_monitor mon_u (.*);
`default_nettype wire

/* simc_src.sv */
`timescale 1ns/10ps
`default_nettype none
module simc_src (
  input wire logic clk, // parallel clock
  input wire logic go, // offer words
  input wire logic din_ready, // block takes word
  output logic din_valid, // word offered
  output logic [9:0] din_lower, din_upper // word lanes
);
  logic [19:0] w_reg = 20'h5A5A5;
  // word held until taken; idle lanes show the inverse
  always @(posedge clk) begin
    if (din_valid && din_ready) w_reg <= 20'($urandom);
    din_valid <= go || (din_valid && !din_ready);
  end
  assign {din_upper, din_lower} = din_valid ? w_reg : ~w_reg;
endmodule // simc_src
`default_nettype wire

/* test_serializer_input_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "simc_consts.vh"
module test_serializer_input_mode_control;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, word_ready = 1'b0;
  logic [5:0] p = 6'h0, t = 6'h0, cfg [4] = '{6'h10, 6'h14, 6'h18, 6'h08};
  wire din_valid, din_ready, rate_sd, word_valid, word_upper_used, tim_h, tim_v, tim_f;
  wire [9:0] din_lower, din_upper, word_lower, word_upper;
  wire [1:0] op_mode, upper_use, timing_src;
  int err_total = 0, check_count = 0;
  logic [19:0] q [$];
  simc_src src_u (.*);
  simc_top dut_u (.*, .rate_select(p[5]), .bus_width_select(p[4]), .processing_enable(p[3]),
    .transport_stream_mode_select(p[2]), .timing_source_select(p[1]),
    .sync_style_select(p[0]), .h_blank(t[5]), .v_blank(t[4]), .f_field(t[3]),
    .h_sync(t[2]), .v_sync(t[1]), .data_en(t[0]));
  ////////////////////////////////////////////////////////////////
  function automatic logic [1:0] ex_up(logic [5:0] v);
    return (!v[4] || (!v[3] && v[2])) ? `SIMC_UPPER_UNUSED :
      v[3] ? `SIMC_UPPER_CHROMA : `SIMC_UPPER_RAW;
  endfunction
  task automatic check(string nm, logic [19:0] seen, logic [19:0] exp);
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
    check_count++;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial forever #25 clk = ~clk;
  initial begin
    #200000;
    err_total++;
    end_of_test;
  end
  always @(posedge clk) begin
    if (!rst && din_valid && din_ready)
      q.push_back({ex_up(p) == `SIMC_UPPER_UNUSED ? 10'h0 : din_upper, din_lower});
    if (!rst && word_valid && word_ready) begin
      check("word", {word_upper, word_lower}, q.pop_front());
      check("used", word_upper_used, ex_up(p) != `SIMC_UPPER_UNUSED);
    end
  end
  initial begin
    void'($urandom(97479));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk);
      p <= 6'(i);
      t <= 6'($urandom);
      @(posedge clk);
      #1;
      check("rate", rate_sd, p[5]);
      check("mode", op_mode, p[3] ? 2'h1 : p[2] ? 2'h2 : 2'h0);
      check("upper", upper_use, ex_up(p));
      check("tsrc", timing_src, p[1] ? 2'h2 : p[0] ? 2'h1 : 2'h0);
      check("tim", {tim_h, tim_v, tim_f}, p[1] ? 3'h0 : p[0] ? t[2:0] : t[5:3]);
    end
    $display("decode test done");
    foreach (cfg[k]) begin
      @(posedge clk);
      p <= cfg[k];
      go <= 1'b1;
      word_ready <= 1'b0;
      repeat (12) @(posedge clk);
      #1;
      check("full", din_ready, 1'b0);
      repeat (40) @(posedge clk) word_ready <= 1'($urandom);
      @(posedge clk);
      go <= 1'b0;
      word_ready <= 1'b1;
      repeat (12) @(posedge clk);
      #1;
      check("drained", 20'(q.size()), 20'h0);
      check("idle", word_valid, 1'b0);
      $display("word test %0d done", k);
    end
    end_of_test;
  end
endmodule // test_serializer_input_mode_control
`default_nettype wire
